/* File: design/rcs_pkg.sv */
// Overview of operation
// - eight recovered clocks: four out, four internal
// - recover timing from 10/100/1000M and 2.5G streams
// - per-output divider: 1,2,4,5,8,16 or 25
// - outputs 0 and 1 overlay gpio pins
// - two copper resources pick copper port 0-3
// - source eleven selects the pll clock
// - pll clock routable to differential output
// - auto squelch recovered clock on signal loss
// - squelched clock stops on loss or unlock
// - squelched clock rests at either level
package rcs_pkg;
    localparam int NUM_CH = 8;
    localparam int NUM_EXT = 4;
    localparam int NUM_LANE = 9;
    localparam int NUM_CU = 4;
    localparam int NUM_GIG = 6;
    localparam int NUM_SIX = 3;
    localparam int NUM_SRC = 16;
    localparam int NUM_SYNC = 24;

    localparam logic [3:0] SRC_LANE_BASE = 4'h2;
    localparam logic [3:0] SRC_SIX_BASE = 4'h6;
    localparam logic [3:0] SRC_PLL = 4'hb;

    localparam logic [7:0] ADDR_OUT_CFG = 8'h00;
    localparam logic [7:0] ADDR_PLL_EXTRA = 8'h20;
    localparam logic [7:0] ADDR_PLL_OUT_CFG = 8'h40;
    localparam logic [7:0] ADDR_CU_RES0 = 8'h44;
    localparam logic [7:0] ADDR_CU_RES1 = 8'h48;
    localparam logic [7:0] ADDR_GIG_CFG = 8'h4c;
    localparam logic [7:0] ADDR_SIX_CFG = 8'h50;
    localparam logic [7:0] ADDR_GPIO_ALT = 8'h54;
    localparam logic [7:0] ADDR_STATUS = 8'h58;
    localparam logic [2:0] BANK_OUT_CFG = 3'h0;
    localparam logic [2:0] BANK_PLL_EXTRA = 3'h1;

    localparam int OUT_EN_BIT = 0;
    localparam int OUT_DIV_LSB = 1;
    localparam int OUT_SRC_LSB = 4;
    localparam int CU_EN_BIT = 0;
    localparam int CU_PORT_LSB = 1;
    localparam int CU_FREQ_BIT = 3;
    localparam int CU_PHY_BIT = 4;
    localparam int HS_EN_BIT = 0;
    localparam int HS_FSEL_LSB = 1;

    localparam logic [7:0] OUT_CFG_RST = 8'h00;
    localparam logic [4:0] CU_CFG_RST = 5'h00;
    localparam logic [2:0] HS_CFG_RST = 3'h0;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [5:0] GIG_SQ_RST = 6'h00;
    localparam logic [2:0] SIX_SQ_RST = 3'h0;
    localparam logic [1:0] GPIO_ALT_RST = 2'h0;
    localparam logic PLL_SQ_RST = 1'b0;

    // last edge count per divider code: ratio 1,2,4,5,8,16,25,1
    localparam logic [5:0] DIV_LAST [8] = '{6'h00, 6'h01, 6'h03, 6'h04,
                                            6'h07, 6'h0f, 6'h18, 6'h00};
endpackage

/* File: design/rcs_clk_div.sv */
module rcs_clk_div (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic edge_evt,
    input wire logic run,
    input wire logic [2:0] div_code,
    output logic clk_out
);
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic out_r;
    logic out_nxt;

    // toggle after n source edges: period is n source periods
    always_comb
    begin
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        if (!run)
        begin
            cnt_nxt = 6'h00;
        end
        else if (edge_evt)
        begin
            if (cnt_r >= rcs_pkg::DIV_LAST[div_code])
            begin
                cnt_nxt = 6'h00;
                out_nxt = ~out_r;
            end
            else
            begin
                cnt_nxt = cnt_r + 6'h01;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cnt_r <= 6'h00;
            out_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign clk_out = out_r;
endmodule

/* File: design/rcs_selector.sv */
module rcs_selector (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [8:0] lane_rx_clk,
    input wire logic [8:0] lane_los,
    input wire logic [3:0] copper_phy_port_clk,
    input wire logic pll_clk,
    input wire logic pll_locked,
    input wire logic [1:0] gpio_data,
    output logic [3:0] rclk_ext_out,
    output logic [3:0] rclk_int_out,
    output logic recovered_clock_pin_0,
    output logic recovered_clock_pin_1,
    output logic hs_clk_p,
    output logic hs_clk_n
);
    // =========================================
    // register state
    // =========================================
    logic [7:0] out_cfg_r [rcs_pkg::NUM_CH];
    logic [7:0] out_cfg_nxt [rcs_pkg::NUM_CH];
    logic pll_sq_r [rcs_pkg::NUM_CH];
    logic pll_sq_nxt [rcs_pkg::NUM_CH];
    logic [4:0] cu_cfg_r [2];
    logic [4:0] cu_cfg_nxt [2];
    logic [2:0] hs_cfg_r;
    logic [2:0] hs_cfg_nxt;
    logic [5:0] gig_sq_r;
    logic [5:0] gig_sq_nxt;
    logic [2:0] six_sq_r;
    logic [2:0] six_sq_nxt;
    logic [1:0] gpio_alt_r;
    logic [1:0] gpio_alt_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;

    // =========================================
    // pin synchronisers and edge tracking
    // =========================================
    logic [rcs_pkg::NUM_SYNC-1:0] sync1_r;
    logic [rcs_pkg::NUM_SYNC-1:0] sync2_r;
    logic [rcs_pkg::NUM_SRC-1:0] lvl_prev_r;
    logic [rcs_pkg::NUM_SRC-1:0] src_lvl;
    logic [rcs_pkg::NUM_SRC-1:0] src_edge;
    logic [rcs_pkg::NUM_SRC-1:0] src_los;
    logic [rcs_pkg::NUM_SRC-1:0] src_sq_en;
    logic [8:0] lane_lvl;
    logic [8:0] los_s;
    logic [3:0] cu_lvl;
    logic pll_lvl;
    logic lock_s;
    logic [1:0] res_lvl;

    // sources above about 12 mhz are not tracked
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            lvl_prev_r <= '0;
        end
        else
        begin
            sync1_r <= {pll_locked, pll_clk, copper_phy_port_clk, lane_los, lane_rx_clk};
            sync2_r <= sync1_r;
            lvl_prev_r <= src_lvl;
        end
    end

    assign lane_lvl = sync2_r[8:0];
    assign los_s = sync2_r[17:9];
    assign cu_lvl = sync2_r[21:18];
    assign pll_lvl = sync2_r[22];
    assign lock_s = sync2_r[23];

    // copper resources pick one of four copper ports
    always_comb
    begin
        for (int r = 0; r < 2; r++)
        begin
            res_lvl[r] = cu_lvl[cu_cfg_r[r][rcs_pkg::CU_PORT_LSB +: 2]]
                & cu_cfg_r[r][rcs_pkg::CU_EN_BIT] & cu_cfg_r[r][rcs_pkg::CU_PHY_BIT];
        end
    end

    // source map: 0-1 copper, 2-10 lanes, 11 pll
    always_comb
    begin
        src_lvl = '0;
        src_lvl[1:0] = res_lvl;
        src_lvl[10:2] = lane_lvl;
        src_lvl[rcs_pkg::SRC_PLL] = pll_lvl;
        src_los = '0;
        src_los[8:0] = los_s;
        src_sq_en = '0;
        src_sq_en[5:0] = gig_sq_r;
        src_sq_en[8:6] = six_sq_r;
    end

    // both edges count, so odd ratios work
    // a source switch gives no stray edge: each source's level is tracked on its own
    assign src_edge = src_lvl ^ lvl_prev_r;

    // =========================================
    // per-channel select, squelch, divide
    // =========================================
    logic [rcs_pkg::NUM_CH-1:0] ch_clk;
    logic [rcs_pkg::NUM_CH-1:0] ch_sq;

    genvar g;
    generate
        for (g = 0; g < rcs_pkg::NUM_CH; g++)
        begin : g_ch
            logic [3:0] src;
            logic ena;
            assign src = out_cfg_r[g][rcs_pkg::OUT_SRC_LSB +: 4];
            assign ena = out_cfg_r[g][rcs_pkg::OUT_EN_BIT];
            // loss of signal or pll unlock freezes the divider level
            assign ch_sq[g] = (src_los[src] & src_sq_en[src])
                | ((src == rcs_pkg::SRC_PLL) & pll_sq_r[g] & ~lock_s);
            rcs_clk_div u_div (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .edge_evt(src_edge[src]),
                .run(ena & ~ch_sq[g]),
                .div_code(out_cfg_r[g][rcs_pkg::OUT_DIV_LSB +: 3]),
                .clk_out(ch_clk[g])
            );
        end
    endgenerate

    // =========================================
    // output pins
    // =========================================
    logic [1:0] pin_r;
    logic [1:0] pin_nxt;
    logic hs_p_r;
    logic hs_p_nxt;
    logic hs_n_r;
    logic hs_n_nxt;

    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            pin_nxt[p] = gpio_alt_r[p] ? ch_clk[p] : gpio_data[p];
        end
        hs_p_nxt = hs_cfg_r[rcs_pkg::HS_EN_BIT] & pll_lvl;
        hs_n_nxt = hs_cfg_r[rcs_pkg::HS_EN_BIT] & ~pll_lvl;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            pin_r <= 2'h0;
            hs_p_r <= 1'b0;
            hs_n_r <= 1'b0;
        end
        else
        begin
            pin_r <= pin_nxt;
            hs_p_r <= hs_p_nxt;
            hs_n_r <= hs_n_nxt;
        end
    end

    // ch_clk comes from divider flops
    assign rclk_ext_out = ch_clk[rcs_pkg::NUM_EXT-1:0];
    assign rclk_int_out = ch_clk[rcs_pkg::NUM_CH-1:rcs_pkg::NUM_EXT];
    assign recovered_clock_pin_0 = pin_r[0];
    assign recovered_clock_pin_1 = pin_r[1];
    assign hs_clk_p = hs_p_r;
    assign hs_clk_n = hs_n_r;

    // =========================================
    // register port
    // =========================================
    logic [2:0] bank;
    logic [2:0] idx;
    logic [17:0] status_word;
    assign bank = reg_addr[7:5];
    assign idx = reg_addr[4:2];
    // status: [8:0] loss, [9] lock, [17:10] squelched
    assign status_word = {ch_sq, lock_s, los_s};

    always_comb
    begin
        out_cfg_nxt = out_cfg_r;
        pll_sq_nxt = pll_sq_r;
        cu_cfg_nxt = cu_cfg_r;
        hs_cfg_nxt = hs_cfg_r;
        gig_sq_nxt = gig_sq_r;
        six_sq_nxt = six_sq_r;
        gpio_alt_nxt = gpio_alt_r;
        if (reg_wr)
        begin
            if (bank == rcs_pkg::BANK_OUT_CFG)
            begin
                out_cfg_nxt[idx] = reg_wdata[7:0];
            end
            else if (bank == rcs_pkg::BANK_PLL_EXTRA)
            begin
                pll_sq_nxt[idx] = reg_wdata[0];
            end
            else
            begin
                case (reg_addr)
                    rcs_pkg::ADDR_PLL_OUT_CFG: hs_cfg_nxt = reg_wdata[2:0];
                    rcs_pkg::ADDR_CU_RES0: cu_cfg_nxt[0] = reg_wdata[4:0];
                    rcs_pkg::ADDR_CU_RES1: cu_cfg_nxt[1] = reg_wdata[4:0];
                    rcs_pkg::ADDR_GIG_CFG: gig_sq_nxt = reg_wdata[5:0];
                    rcs_pkg::ADDR_SIX_CFG: six_sq_nxt = reg_wdata[2:0];
                    rcs_pkg::ADDR_GPIO_ALT: gpio_alt_nxt = reg_wdata[1:0];
                    default: gpio_alt_nxt = gpio_alt_r;
                endcase
            end
        end
    end

    always_comb
    begin
        rdata_nxt = 32'h0000_0000;
        if (reg_rd)
        begin
            if (bank == rcs_pkg::BANK_OUT_CFG)
            begin
                rdata_nxt[7:0] = out_cfg_r[idx];
            end
            else if (bank == rcs_pkg::BANK_PLL_EXTRA)
            begin
                rdata_nxt[0] = pll_sq_r[idx];
            end
            else
            begin
                case (reg_addr)
                    rcs_pkg::ADDR_PLL_OUT_CFG: rdata_nxt[2:0] = hs_cfg_r;
                    rcs_pkg::ADDR_CU_RES0: rdata_nxt[4:0] = cu_cfg_r[0];
                    rcs_pkg::ADDR_CU_RES1: rdata_nxt[4:0] = cu_cfg_r[1];
                    rcs_pkg::ADDR_GIG_CFG: rdata_nxt[5:0] = gig_sq_r;
                    rcs_pkg::ADDR_SIX_CFG: rdata_nxt[2:0] = six_sq_r;
                    rcs_pkg::ADDR_GPIO_ALT: rdata_nxt[1:0] = gpio_alt_r;
                    rcs_pkg::ADDR_STATUS: rdata_nxt[17:0] = status_word;
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < rcs_pkg::NUM_CH; i++)
            begin
                out_cfg_r[i] <= rcs_pkg::OUT_CFG_RST;
                pll_sq_r[i] <= rcs_pkg::PLL_SQ_RST;
            end
            cu_cfg_r[0] <= rcs_pkg::CU_CFG_RST;
            cu_cfg_r[1] <= rcs_pkg::CU_CFG_RST;
            hs_cfg_r <= rcs_pkg::HS_CFG_RST;
            gig_sq_r <= rcs_pkg::GIG_SQ_RST;
            six_sq_r <= rcs_pkg::SIX_SQ_RST;
            gpio_alt_r <= rcs_pkg::GPIO_ALT_RST;
        end
        else
        begin
            out_cfg_r <= out_cfg_nxt;
            pll_sq_r <= pll_sq_nxt;
            cu_cfg_r <= cu_cfg_nxt;
            hs_cfg_r <= hs_cfg_nxt;
            gig_sq_r <= gig_sq_nxt;
            six_sq_r <= six_sq_nxt;
            gpio_alt_r <= gpio_alt_nxt;
        end
    end

    // =========================================
    // read data register
    // =========================================
    // answer stands one cycle, zero otherwise
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            rdata_r <= rcs_pkg::RDATA_RST;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
endmodule

/* File: bench/rcs_far_model.sv */
module rcs_far_model (
    output logic [8:0] lane_rx_clk,
    output logic [3:0] copper_phy_port_clk,
    output logic pll_clk
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // lanes and pll: level change every 100 ns
    initial
    begin
        lane_rx_clk = '0;
        pll_clk = 1'b0;
        #3.3;
        forever
        begin
            #100;
            lane_rx_clk = ~lane_rx_clk;
            pll_clk = ~pll_clk;
        end
    end
    // copper port k: level change every 60(k+1) ns
    for (genvar k = 0; k < 4; k++)
    begin : g_cu
        initial
        begin
            copper_phy_port_clk[k] = 1'b0;
            #1.7;
            forever #(60 * (k + 1)) copper_phy_port_clk[k] = ~copper_phy_port_clk[k];
        end
    end
endmodule

/* File: bench/rcs_selector_asserts.sv */
module rcs_selector_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [8:0] lane_los,
    input wire logic [1:0] gpio_data,
    input wire logic [3:0] rclk_ext_out,
    input wire logic recovered_clock_pin_0,
    input wire logic recovered_clock_pin_1,
    input wire logic hs_clk_p,
    input wire logic hs_clk_n
);
    // ==========
    // register shadows
    logic [7:0] cfg0_r, cfg1_r;
    logic [5:0] gig_r;
    logic hs_en_r;
    logic [1:0] ovl_r;
    logic sq1;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            cfg0_r <= 8'h00;
            cfg1_r <= 8'h00;
            gig_r <= 6'h00;
            hs_en_r <= 1'b0;
            ovl_r <= 2'h0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == 8'h00) cfg0_r <= reg_wdata[7:0];
            if (reg_addr == 8'h04) cfg1_r <= reg_wdata[7:0];
            if (reg_addr == rcs_pkg::ADDR_GIG_CFG) gig_r <= reg_wdata[5:0];
            if (reg_addr == rcs_pkg::ADDR_PLL_OUT_CFG) hs_en_r <= reg_wdata[0];
            if (reg_addr == rcs_pkg::ADDR_GPIO_ALT) ovl_r <= reg_wdata[1:0];
        end
    end
    assign sq1 = cfg1_r[0] && cfg1_r[7:4] == 4'h2 && gig_r[2] && lane_los[2];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // properties
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read answer");
    unmapped_rd_a: assert property (reg_rd && reg_addr == 8'hfc |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    readback_a: assert property (reg_rd && reg_addr == 8'h00
        |=> reg_rdata == {24'h0, $past(cfg0_r)})
        else $error("output config readback wrong");
    ext_off_a: assert property ((!cfg0_r[0])[*6] |-> $stable(rclk_ext_out[0]))
        else $error("disabled output toggled");
    squelch_hold_a: assert property (sq1[*8] |-> $stable(rclk_ext_out[1]))
        else $error("squelched output toggled");
    hs_off_a: assert property ((!hs_en_r)[*3] |-> !hs_clk_p && !hs_clk_n)
        else $error("high speed output active while off");
    hs_pair_a: assert property (hs_en_r[*4] |-> hs_clk_n == !hs_clk_p)
        else $error("high speed pair not complementary");
    pin0_gpio_a: assert property ((!ovl_r[0])[*2]
        |-> recovered_clock_pin_0 == $past(gpio_data[0]))
        else $error("pin 0 not following gpio");
    pin1_alt_a: assert property (ovl_r[1][*2]
        |-> recovered_clock_pin_1 == $past(rclk_ext_out[1]))
        else $error("pin 1 not following channel 1");
    cover property (sq1[*8]);
    cover property (ovl_r[1][*2]);
    cover property (hs_en_r[*4]);
endmodule

bind rcs_selector rcs_selector_asserts chk_u (.core_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .lane_los, .gpio_data, .rclk_ext_out,
    .recovered_clock_pin_0, .recovered_clock_pin_1, .hs_clk_p, .hs_clk_n);

/* File: bench/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk, rst_n, reg_wr, reg_rd, pll_locked, pll_clk, pin0, pin1, hs_p, hs_n;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [8:0] lane_rx_clk, lane_los;
    logic [3:0] cu_clk, ext_o, int_o;
    logic [1:0] gpio_data;
    logic [10:0] watch;
    int miscompares, n_compared;
    int ratio [7] = '{1, 2, 4, 5, 8, 16, 25};
    assign watch = {pin1, pin0, hs_p, int_o, ext_o};
    rcs_far_model far_u (.lane_rx_clk(lane_rx_clk), .copper_phy_port_clk(cu_clk),
        .pll_clk(pll_clk));
    rcs_selector dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .lane_rx_clk(lane_rx_clk), .lane_los(lane_los), .copper_phy_port_clk(cu_clk),
        .pll_clk(pll_clk), .pll_locked(pll_locked), .gpio_data(gpio_data),
        .rclk_ext_out(ext_o), .rclk_int_out(int_o), .recovered_clock_pin_0(pin0),
        .recovered_clock_pin_1(pin1), .hs_clk_p(hs_p), .hs_clk_n(hs_n));
    // ==========
    // tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask
    // level changes of watch[idx] within win cycles, one either way unless exp is 0
    task automatic toggles(input int idx, input int win, input int exp);
        int n;
        logic last;
        n = 0;
        repeat (20) @(posedge core_clk);
        last = watch[idx];
        repeat (win)
        begin
            @(posedge core_clk);
            #1;
            if (watch[idx] !== last) n++;
            last = watch[idx];
        end
        check("toggles", (n >= exp - 1 && n <= exp + 1 && (exp > 0 || n == 0)) ? 32'(exp)
            : 32'(n), 32'(exp));
    endtask
    task automatic final_report;
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========
    // sequence
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial
    begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        lane_los = 9'h000;
        pll_locked = 1'b1;
        gpio_data = 2'h2;
        miscompares = 0;
        n_compared = 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(8'h00, 32'h0000_0000);
        wr(8'hfc, 32'hffff_ffff);
        rd(8'hfc, 32'h0000_0000);
        for (int c = 0; c < 7; c++)
        begin
            wr(8'h00, 32'(8'h21 | (c << 1)));
            rd(8'h00, 32'(8'h21 | (c << 1)));
            toggles(0, 2000, 400 / ratio[c]);
        end
        wr(8'h00, 32'h0000_0000);
        toggles(0, 500, 0);
        wr(8'h10, 32'h0000_00a9);
        toggles(4, 2000, 50);
        wr(8'h0c, 32'h0000_00b3);
        toggles(3, 2000, 200);
        wr(8'h44, 32'h0000_001f);
        wr(8'h08, 32'h0000_0003);
        toggles(2, 2400, 100);
        wr(8'h44, 32'h0000_001e);
        toggles(2, 500, 0);
        wr(8'h48, 32'h0000_0013);
        wr(8'h08, 32'h0000_001f);
        toggles(2, 1200, 200);
        wr(8'h08, 32'h0000_00c1);
        toggles(2, 500, 0);
        wr(8'h40, 32'h0000_0003);
        toggles(8, 1000, 200);
        check("hs_pair", 32'(hs_p ^ hs_n), 32'h0000_0001);
        check("pin0", 32'(pin0), 32'h0000_0000);
        check("pin1", 32'(pin1), 32'h0000_0001);
        @(posedge core_clk);
        gpio_data <= 2'h1;
        repeat (2) @(posedge core_clk);
        #1;
        check("pin0", 32'(pin0), 32'h0000_0001);
        check("pin1", 32'(pin1), 32'h0000_0000);
        wr(8'h04, 32'h0000_0021);
        wr(8'h54, 32'h0000_0003);
        toggles(10, 2000, 400);
        wr(8'h4c, 32'h0000_0004);
        lane_los <= 9'h004;
        toggles(1, 500, 0);
        rd(8'h58, 32'h0000_0a04);
        wr(8'h4c, 32'h0000_0000);
        toggles(1, 1000, 200);
        @(posedge core_clk) lane_los <= 9'h000;
        wr(8'h10, 32'h0000_0061);
        wr(8'h50, 32'h0000_0001);
        lane_los <= 9'h040;
        toggles(4, 500, 0);
        @(posedge core_clk) lane_los <= 9'h000;
        toggles(4, 1000, 200);
        wr(8'h2c, 32'h0000_0001);
        pll_locked <= 1'b0;
        toggles(3, 500, 0);
        final_report();
    end
endmodule
